// *** port_power_monitor_pkg.sv ***
// Shared constants for the port power monitor and overcurrent trip block
//------------------------------------------------------------------------
//------------------------------------------------------------------------
package port_power_monitor_pkg;

   localparam int unsigned CLK_PERIOD_NS = 20;
   localparam int unsigned NUM_PORTS     = 8;
   localparam int unsigned NUM_SIG       = 2 * NUM_PORTS + 1;
   localparam int unsigned IDX_W         = 5;
   localparam int unsigned SAMPLE_W      = 12;

   // Schedule index: 2*port is voltage, 2*port+1 is current, last is supply
   localparam logic [4:0]  FIRST_IDX     = 5'h00;
   localparam logic [4:0]  SUPPLY_IDX    = 5'h10;

   localparam logic [11:0] LIMIT_MAX     = 12'h0fff;
   localparam logic [11:0] FILTER_RST    = 12'h0000;
   localparam int unsigned EMA_SHIFT     = 2;

   localparam int unsigned SLOT_NS       = 140000;
   localparam int unsigned SLOT_CYC      = SLOT_NS / CLK_PERIOD_NS;
   localparam int unsigned TTRIP_NS      = 1000000;
   localparam int unsigned TTRIP_CYC     = TTRIP_NS / CLK_PERIOD_NS;
   localparam int unsigned TLIMIT_NS     = 700;
   localparam int unsigned TLIMIT_CYC    = (TLIMIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : port_power_monitor_pkg

// *** ppm_slot_seq.sv ***
// Conversion slot timer and signal schedule
`timescale 1ns/10ps
module ppm_slot_seq
   import port_power_monitor_pkg::*;
#(
   parameter int unsigned SLOT_CYC_P = SLOT_CYC
)
(
   input  wire logic             clk_i,
   input  wire logic             rst_n_i,
   output logic      [IDX_W-1:0] slot_idx_o,
   output logic                  slot_end_o
);

   localparam int unsigned TW = $clog2(SLOT_CYC_P + 1);
   localparam logic [TW-1:0] SLOT_LAST = TW'(SLOT_CYC_P - 1);

   typedef struct packed {
      logic [TW-1:0]    timer;
      logic [IDX_W-1:0] idx;
   } seq_s;

   seq_s st_q;
   seq_s st_d;

   always_comb
   begin
      st_d = st_q;
      st_d.timer = st_q.timer + TW'(1);
      if (st_q.timer == SLOT_LAST)
      begin
         st_d.timer = '0;
         st_d.idx   = (st_q.idx == SUPPLY_IDX) ? FIRST_IDX : st_q.idx + 5'h01;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         st_q <= '{timer: '0, idx: FIRST_IDX};
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign slot_idx_o = st_q.idx;
   assign slot_end_o = (st_q.timer == SLOT_LAST);

   //---------------------------------------------------------------
   // Checks
   //---------------------------------------------------------------
   AST_SLOT_ADVANCE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      slot_end_o |=> slot_idx_o == (($past(slot_idx_o) == SUPPLY_IDX) ? FIRST_IDX
                                    : $past(slot_idx_o) + 5'h01))
      else $error("Schedule did not advance at slot end");
   AST_SLOT_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !slot_end_o |=> $stable(slot_idx_o))
      else $error("Schedule moved inside a slot");
   AST_RESET_START: assert property (@(posedge clk_i)
      !rst_n_i |=> slot_idx_o == FIRST_IDX && st_q.timer == '0)
      else $error("Schedule not at first port after reset");

endmodule : ppm_slot_seq

// *** ppm_ema_filter.sv ***
// Per-signal first-order exponential averaging store
`timescale 1ns/10ps
module ppm_ema_filter
   import port_power_monitor_pkg::*;
(
   input  wire logic                clk_i,
   input  wire logic                rst_n_i,
   input  wire logic                upd_i,
   input  wire logic [IDX_W-1:0]    idx_i,
   input  wire logic [SAMPLE_W-1:0] sample_i,
   input  wire logic [IDX_W-1:0]    rd_idx_i,
   output logic      [SAMPLE_W-1:0] new_val_o,
   output logic      [SAMPLE_W-1:0] rd_data_o
);

   typedef struct packed {
      logic [NUM_SIG-1:0][SAMPLE_W-1:0] acc;
      logic [SAMPLE_W-1:0]              rd;
   } filt_s;

   filt_s st_q;
   filt_s st_d;

   logic        [SAMPLE_W-1:0] prev;
   logic signed [SAMPLE_W:0]   diff;
   logic signed [SAMPLE_W:0]   step;

   always_comb
   begin
      prev = st_q.acc[idx_i];
      diff = $signed({1'b0, sample_i}) - $signed({1'b0, prev});
      step = diff >>> EMA_SHIFT;
      // True result stays in range, so modular add is exact
      new_val_o = prev + step[SAMPLE_W-1:0];
      st_d = st_q;
      if (upd_i)
      begin
         st_d.acc[idx_i] = new_val_o;
      end
      st_d.rd = st_q.acc[rd_idx_i];
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         st_q <= '{acc: {NUM_SIG{FILTER_RST}}, rd: FILTER_RST};
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign rd_data_o = st_q.rd;

   AST_EMA_STEP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      upd_i |=> st_q.acc[$past(idx_i)] == SAMPLE_W'($past(prev)
         + SAMPLE_W'(($signed({1'b0, $past(sample_i)})
         - $signed({1'b0, $past(prev)})) >>> EMA_SHIFT)))
      else $error("Average update wrong");

endmodule : ppm_ema_filter

// *** port_power_monitor_trip.sv ***
// Port supply measurement sequencer, overcurrent breaker and power gating
`timescale 1ns/10ps
module port_power_monitor_trip
   import port_power_monitor_pkg::*;
#(
   parameter int unsigned SLOT_CYC_P = SLOT_CYC,
   parameter int unsigned TRIP_CYC_P = TTRIP_CYC
)
(
   input  wire logic                          CLK_SYS_I,
   input  wire logic                          RST_N_I,
   output logic                               CONV_REQ_O,
   output logic      [IDX_W-1:0]              CONV_SEL_O,
   input  wire logic                          CONV_ACK_I,
   input  wire logic [SAMPLE_W-1:0]           CONV_DATA_I,
   input  wire logic [NUM_PORTS-1:0]          SC_OVER_I,
   input  wire logic                          BUS_POWER_ONLY_I,
   input  wire logic [NUM_PORTS-1:0]          PORT_ENABLE_I,
   input  wire logic [NUM_PORTS*SAMPLE_W-1:0] PORT_LIMIT_I,
   input  wire logic [NUM_PORTS-1:0]          OC_CLEAR_I,
   input  wire logic [IDX_W-1:0]              RD_INDEX_I,
   output logic      [SAMPLE_W-1:0]           RD_DATA_O,
   output logic                               MEAS_VALID_O,
   output logic      [IDX_W-1:0]              MEAS_INDEX_O,
   output logic      [SAMPLE_W-1:0]           MEAS_DATA_O,
   output logic      [NUM_PORTS-1:0]          PORT_PWR_O,
   output logic      [NUM_PORTS-1:0]          OC_FLAG_O,
   output logic      [NUM_PORTS-1:0]          SC_MODE_O
);

   localparam int unsigned TW = $clog2(TRIP_CYC_P + 1);
   localparam int unsigned SW = $clog2(TLIMIT_CYC + 1);
   localparam logic [TW-1:0] TRIP_LAST = TW'(TRIP_CYC_P - 1);
   localparam logic [SW-1:0] SC_LAST   = SW'(TLIMIT_CYC - 1);

   typedef struct packed {
      logic                         ack_s1;
      logic                         ack_s2;
      logic [SAMPLE_W-1:0]          data_s1;
      logic [SAMPLE_W-1:0]          data_s2;
      logic [NUM_PORTS-1:0]         sc_s1;
      logic [NUM_PORTS-1:0]         sc_s2;
      logic                         bp_s1;
      logic                         bp_s2;
      logic                         req;
      logic [IDX_W-1:0]             sel;
      logic                         got;
      logic [SAMPLE_W-1:0]          cap;
      logic                         meas_valid;
      logic [IDX_W-1:0]             meas_idx;
      logic [SAMPLE_W-1:0]          meas_data;
      logic [NUM_PORTS-1:0]         en_prev;
      logic [NUM_PORTS-1:0]         oc;
      logic [NUM_PORTS-1:0]         run;
      logic [NUM_PORTS-1:0]         off;
      logic [NUM_PORTS-1:0][TW-1:0] trip_cnt;
      logic [NUM_PORTS-1:0]         sc_mode;
      logic [NUM_PORTS-1:0][SW-1:0] sc_cnt;
      logic [NUM_PORTS-1:0]         pwr;
   } mon_s;

   mon_s st_q;
   mon_s st_d;

   logic [IDX_W-1:0]     slot_idx;
   logic                 slot_end;
   logic                 upd;
   logic [SAMPLE_W-1:0]  new_val;
   logic                 is_cur;
   logic [2:0]           cur_port;
   logic [SAMPLE_W-1:0]  cur_limit;
   logic [NUM_PORTS-1:0] hit;
   logic [NUM_PORTS-1:0] clr;

   //---------------------------------------------------------------
   // Schedule and averaging
   //---------------------------------------------------------------
   ppm_slot_seq #(
      .SLOT_CYC_P (SLOT_CYC_P)
   ) u_seq (
      .clk_i      (CLK_SYS_I),
      .rst_n_i    (RST_N_I),
      .slot_idx_o (slot_idx),
      .slot_end_o (slot_end)
   );

   ppm_ema_filter u_filt (
      .clk_i     (CLK_SYS_I),
      .rst_n_i   (RST_N_I),
      .upd_i     (upd),
      .idx_i     (st_q.sel),
      .sample_i  (st_q.cap),
      .rd_idx_i  (RD_INDEX_I),
      .new_val_o (new_val),
      .rd_data_o (RD_DATA_O)
   );

   //---------------------------------------------------------------
   // Next state
   //---------------------------------------------------------------
   always_comb
   begin
      st_d = st_q;
      st_d.ack_s1  = CONV_ACK_I;
      st_d.ack_s2  = st_q.ack_s1;
      st_d.data_s1 = CONV_DATA_I;
      st_d.data_s2 = st_q.data_s1;
      st_d.sc_s1   = SC_OVER_I;
      st_d.sc_s2   = st_q.sc_s1;
      st_d.bp_s1   = BUS_POWER_ONLY_I;
      st_d.bp_s2   = st_q.bp_s1;

      // Four-phase handshake; a late answer is kept and used at the next slot end
      if (!st_q.req && !st_q.got && !st_q.ack_s2)
      begin
         st_d.req = 1'b1;
         st_d.sel = slot_idx;
      end
      else if (st_q.req && st_q.ack_s2)
      begin
         st_d.req = 1'b0;
         st_d.got = 1'b1;
         st_d.cap = st_q.data_s2;
      end

      upd       = slot_end && st_q.got;
      is_cur    = st_q.sel[0] && (st_q.sel != SUPPLY_IDX);
      cur_port  = st_q.sel[3:1];
      cur_limit = PORT_LIMIT_I[cur_port*SAMPLE_W +: SAMPLE_W];
      st_d.meas_valid = upd;
      if (upd)
      begin
         st_d.got       = 1'b0;
         st_d.meas_idx  = st_q.sel;
         st_d.meas_data = new_val;
      end

      for (int p = 0; p < NUM_PORTS; p++)
      begin
         // Raw sample, not the average
         hit[p] = upd && is_cur && (cur_port == 3'(p))
                  && (st_q.cap > cur_limit);
         clr[p] = OC_CLEAR_I[p] || (PORT_ENABLE_I[p] && !st_q.en_prev[p]);
         st_d.oc[p] = hit[p] || (st_q.oc[p] && !clr[p]);
         if (hit[p] && !st_q.run[p] && !st_q.off[p])
         begin
            st_d.run[p]      = 1'b1;
            st_d.trip_cnt[p] = '0;
         end
         else if (st_q.run[p])
         begin
            st_d.trip_cnt[p] = st_q.trip_cnt[p] + TW'(1);
            if (st_q.trip_cnt[p] == TRIP_LAST)
            begin
               st_d.run[p] = 1'b0;
               st_d.off[p] = 1'b1;
            end
         end
         // Software action cancels a pending trip unless a new one lands now
         if (clr[p] && !hit[p])
         begin
            st_d.run[p] = 1'b0;
            st_d.off[p] = 1'b0;
         end

         if (st_q.sc_s2[p])
         begin
            if (!st_q.sc_mode[p])
            begin
               st_d.sc_cnt[p] = st_q.sc_cnt[p] + SW'(1);
               st_d.sc_mode[p] = (st_q.sc_cnt[p] == SC_LAST);
            end
         end
         else
         begin
            st_d.sc_cnt[p]  = '0;
            st_d.sc_mode[p] = 1'b0;
         end

         st_d.pwr[p] = PORT_ENABLE_I[p] && !st_d.off[p] && !st_q.bp_s2;
      end
      st_d.en_prev = PORT_ENABLE_I;
   end

   always_ff @(posedge CLK_SYS_I)
   begin
      if (!RST_N_I)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   //---------------------------------------------------------------
   // Outputs
   //---------------------------------------------------------------
   assign CONV_REQ_O   = st_q.req;
   assign CONV_SEL_O   = st_q.sel;
   assign MEAS_VALID_O = st_q.meas_valid;
   assign MEAS_INDEX_O = st_q.meas_idx;
   assign MEAS_DATA_O  = st_q.meas_data;
   assign PORT_PWR_O   = st_q.pwr;
   assign OC_FLAG_O    = st_q.oc;
   assign SC_MODE_O    = st_q.sc_mode;

   //---------------------------------------------------------------
   // Checks
   //---------------------------------------------------------------
   AST_BUS_POWER_OFF: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
      st_q.bp_s2 |=> PORT_PWR_O == '0)
      else $error("Port powered while on upstream bus power");

   AST_TRIP_FLAG: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
      (upd && is_cur && st_q.cap > cur_limit) |=> OC_FLAG_O[$past(cur_port)])
      else $error("Overcurrent sample did not set flag");

   AST_TRIP_DELAY: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
      $rose(st_q.off[2]) |-> $past(st_q.trip_cnt[2]) == TRIP_LAST && $past(st_q.run[2]))
      else $error("Port cut before trip delay elapsed");

   AST_TRIP_POWER: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
      st_q.off[2] |-> !PORT_PWR_O[2])
      else $error("Tripped port still powered");

   AST_OFF_HOLDS: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
      (st_q.off[2] && !OC_CLEAR_I[2] && !(PORT_ENABLE_I[2] && !st_q.en_prev[2]))
      |=> st_q.off[2] && OC_FLAG_O[2])
      else $error("Tripped port released without software");

   AST_SC_ENTRY: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
      $rose(SC_MODE_O[4]) |-> $past(st_q.sc_s2[4], 1) && $past(st_q.sc_cnt[4]) == SC_LAST)
      else $error("Short-circuit mode entered at wrong time");

   AST_SC_EXIT: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
      !st_q.sc_s2[4] |=> !SC_MODE_O[4])
      else $error("Short-circuit mode held after overcurrent gone");

   AST_REQ_RELEASE: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
      (CONV_REQ_O && st_q.ack_s2) |=> !CONV_REQ_O && st_q.got ##1 !CONV_REQ_O)
      else $error("Request not dropped after answer");

   AST_MEAS_PULSE: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
      MEAS_VALID_O |=> !MEAS_VALID_O)
      else $error("Result strobe longer than one cycle");

   COV_TRIP: cover property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
      $rose(st_q.off[2]));
   COV_SC: cover property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
      $rose(SC_MODE_O[4]));
   COV_SUPPLY: cover property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
      MEAS_VALID_O && MEAS_INDEX_O == SUPPLY_IDX);
   COV_CLEAR: cover property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
      st_q.off[2] ##1 !st_q.off[2]);

endmodule : port_power_monitor_trip

// *** conv_model.sv ***
// Behavioural sensing converter on the four-phase conversion link
`timescale 1ns/10ps
module conv_model
   import port_power_monitor_pkg::*;
(
   input  wire logic                        clk_i,
   input  wire logic                        req_i,
   input  wire logic [IDX_W-1:0]            sel_i,
   input  wire logic [NUM_SIG*SAMPLE_W-1:0] tab_i,
   input  wire logic [7:0]                  lag_i,
   output logic                             ack_o,
   output logic      [SAMPLE_W-1:0]         data_o
);
   //---------------------------------------------
   // Handshake
   //---------------------------------------------
   initial
   begin
      ack_o  = 1'b0;
      data_o = 12'h0a5a;
      forever
      begin
         @(posedge clk_i);
         if (req_i === 1'b1)
         begin
            // Slow answers come from the lag input
            repeat (lag_i) @(posedge clk_i);
            data_o <= tab_i[sel_i*SAMPLE_W +: SAMPLE_W];
            // Data settles three clocks before the answer
            repeat (3) @(posedge clk_i);
            ack_o <= 1'b1;
            @(posedge clk_i);
            while (req_i === 1'b1)
               @(posedge clk_i);
            ack_o  <= 1'b0;
            // Released bus must not keep showing the sample
            data_o <= ~data_o;
         end
      end
   end
endmodule : conv_model

// *** tb_port_power_monitor_trip.sv ***
// Self-checking bench for the port power monitor and overcurrent trip block
`timescale 1ns/10ps
module tb_port_power_monitor_trip;
   import port_power_monitor_pkg::*;

   //---------------------------------------------
   // Signals
   //---------------------------------------------
   localparam int unsigned SLOT = 40;
   localparam int unsigned TRIP = 20;

   typedef struct packed {
      logic [SAMPLE_W-1:0] smp;
      logic [SAMPLE_W-1:0] avg;
   } row_s;

   row_s rows [NUM_SIG] = '{'{12'h0003, 12'h0000}, '{12'h0100, 12'h0040},
      '{12'h0fff, 12'h03ff}, '{12'h0802, 12'h0200}, '{12'h0007, 12'h0001},
      '{12'h0010, 12'h0004}, '{12'h0010, 12'h0004}, '{12'h0444, 12'h0111},
      '{12'h0800, 12'h0200}, '{12'h0123, 12'h0048}, '{12'h0f00, 12'h03c0},
      '{12'h0004, 12'h0001}, '{12'h0555, 12'h0155}, '{12'h0201, 12'h0080},
      '{12'h0c00, 12'h0300}, '{12'h0002, 12'h0000}, '{12'h0fff, 12'h03ff}};

   logic                          clk_sys;
   logic                          rst_n;
   logic                          conv_req;
   logic                          conv_ack;
   logic                          bus_only;
   logic                          meas_valid;
   logic [IDX_W-1:0]              conv_sel;
   logic [IDX_W-1:0]              rd_index;
   logic [IDX_W-1:0]              meas_index;
   logic [SAMPLE_W-1:0]           conv_data;
   logic [SAMPLE_W-1:0]           rd_data;
   logic [SAMPLE_W-1:0]           meas_data;
   logic [NUM_PORTS-1:0]          sc_over;
   logic [NUM_PORTS-1:0]          enable;
   logic [NUM_PORTS-1:0]          oc_clear;
   logic [NUM_PORTS-1:0]          port_pwr;
   logic [NUM_PORTS-1:0]          oc_flag;
   logic [NUM_PORTS-1:0]          sc_mode;
   logic [NUM_PORTS*SAMPLE_W-1:0] limit;
   logic [NUM_SIG*SAMPLE_W-1:0]   tab;
   logic [SAMPLE_W-1:0]           avg [NUM_SIG];
   logic [SAMPLE_W-1:0]           nxt [NUM_SIG];
   logic [7:0]                    lag;
   int                            n_errors;
   int                            n_tests;
   time                           t_last;
   time                           t_trip;
   time                           t_off;

   always #10 clk_sys = ~clk_sys;
   always @(negedge port_pwr[2]) t_off = $time;

   port_power_monitor_trip #(.SLOT_CYC_P(SLOT), .TRIP_CYC_P(TRIP)) u_port_power_monitor_trip (
      .CLK_SYS_I(clk_sys), .RST_N_I(rst_n), .CONV_REQ_O(conv_req), .CONV_SEL_O(conv_sel),
      .CONV_ACK_I(conv_ack), .CONV_DATA_I(conv_data), .SC_OVER_I(sc_over),
      .BUS_POWER_ONLY_I(bus_only), .PORT_ENABLE_I(enable), .PORT_LIMIT_I(limit),
      .OC_CLEAR_I(oc_clear), .RD_INDEX_I(rd_index), .RD_DATA_O(rd_data),
      .MEAS_VALID_O(meas_valid), .MEAS_INDEX_O(meas_index), .MEAS_DATA_O(meas_data),
      .PORT_PWR_O(port_pwr), .OC_FLAG_O(oc_flag), .SC_MODE_O(sc_mode));

   conv_model u_conv_model (.clk_i(clk_sys), .req_i(conv_req), .sel_i(conv_sel),
      .tab_i(tab), .lag_i(lag), .ack_o(conv_ack), .data_o(conv_data));

   //---------------------------------------------
   // Tasks
   //---------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_tests++;
      if (got !== exp)
      begin
         n_errors++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : give_verdict

   function automatic logic [SAMPLE_W-1:0] ema(input logic [11:0] o, input logic [11:0] s);
      logic signed [13:0] d;
      d = $signed({2'b00, s}) - $signed({2'b00, o});
      return o + 12'(d >>> 2);
   endfunction : ema

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : cyc

   task automatic setn(input logic [SAMPLE_W-1:0] v);
      for (int i = 0; i < NUM_SIG; i++)
         nxt[i] = v;
   endtask : setn

   // Waits for the next update and loads the next round's sample
   task automatic take(input logic [IDX_W-1:0] idx, input logic [SAMPLE_W-1:0] exp);
      int k;
      k = 0;
      cyc(1);
      while (meas_valid !== 1'b1 && k < 3 * SLOT)
      begin
         cyc(1);
         k++;
      end
      if (t_last != 0)
         chk(32'($time - t_last), SLOT * 20, "slot spacing");
      t_last = $time;
      chk(meas_index, idx, "schedule index");
      chk(meas_data, exp, "filtered value");
      @(posedge clk_sys);
      rd_index <= idx;
      tab[idx*SAMPLE_W +: SAMPLE_W] <= nxt[idx];
      cyc(2);
      chk(rd_data, exp, "stored value");
   endtask : take

   task automatic round();
      logic [SAMPLE_W-1:0] e;
      for (int i = 0; i < NUM_SIG; i++)
      begin
         e = ema(avg[i], tab[i*SAMPLE_W +: SAMPLE_W]);
         take(5'(i), e);
         avg[i] = e;
      end
   endtask : round

   task automatic trip_watch();
      int k;
      k = 0;
      while (!(meas_valid === 1'b1 && meas_index === 5'h05) && k < 20 * SLOT)
      begin
         cyc(1);
         k++;
      end
      t_trip = $time;
      chk(meas_data < 12'h0100, 1'b1, "average below limit");
      cyc(1);
      chk(oc_flag, 8'h04, "trip flag");
      cyc(TRIP + 4);
      chk(port_pwr, 8'hfb, "tripped port off");
      k = int'((t_off - t_trip + 1) / 20);
      chk(k >= TRIP && k <= TRIP + 2, 1'b1, "disconnect delay");
   endtask : trip_watch

   task automatic side();
      @(posedge clk_sys);
      oc_clear <= 8'h04;
      @(posedge clk_sys);
      oc_clear <= 8'h00;
      cyc(4);
      chk({oc_flag, port_pwr}, 16'h00ff, "trip cleared");
      @(posedge clk_sys);
      enable <= 8'h7f;
      cyc(3);
      chk(port_pwr, 8'h7f, "port disabled");
      @(posedge clk_sys);
      enable   <= 8'hff;
      bus_only <= 1'b1;
      cyc(6);
      chk(port_pwr, 8'h00, "bus powered only");
      @(posedge clk_sys);
      bus_only <= 1'b0;
      sc_over  <= 8'h10;
      cyc(33);
      chk(sc_mode, 8'h00, "short entry early");
      cyc(8);
      chk({sc_mode, port_pwr}, 16'h10ff, "short mode");
      @(posedge clk_sys);
      sc_over <= 8'h00;
      cyc(4);
      chk(sc_mode, 8'h00, "short mode left");
   endtask : side

   //---------------------------------------------
   // Sequence
   //---------------------------------------------
   initial
   begin
      // Five rounds of seventeen slots plus margin
      #(20 * 12000);
      n_errors++;
      $display("unexpected at %0t: watchdog expired", $time);
      give_verdict();
   end

   initial
   begin
      clk_sys  = 1'b0;
      rst_n    = 1'b0;
      bus_only = 1'b0;
      sc_over  = 8'h00;
      enable   = 8'hff;
      oc_clear = 8'h00;
      rd_index = 5'h00;
      lag      = 8'h00;
      limit    = {NUM_PORTS{LIMIT_MAX}};
      n_errors = 0;
      n_tests  = 0;
      t_last   = 0;
      for (int i = 0; i < NUM_SIG; i++)
      begin
         tab[i*SAMPLE_W +: SAMPLE_W] = rows[i].smp;
         avg[i] = rows[i].avg;
      end
      setn(12'h0010);
      nxt[3] = 12'h0100;
      nxt[5] = 12'h0101;
      cyc(19);
      chk({port_pwr, oc_flag, conv_req}, 17'h00000, "outputs in reset");
      @(posedge clk_sys);
      rst_n <= 1'b1;
      for (int i = 0; i < NUM_SIG; i++)
         take(5'(i), rows[i].avg);
      $display("test first round finished");
      setn(12'h0800);
      @(posedge clk_sys);
      limit[SAMPLE_W +: 2*SAMPLE_W] <= {2{12'h0100}};
      fork
         round();
         trip_watch();
      join
      chk({oc_flag, port_pwr}, 16'h04fb, "trip held");
      $display("test trip finished");
      setn(12'h0ff0);
      @(posedge clk_sys);
      limit <= {NUM_PORTS{LIMIT_MAX}};
      fork
         round();
         side();
      join
      $display("test clear, gating and short finished");
      @(posedge clk_sys);
      lag <= 8'h0f;
      round();
      $display("test slow converter finished");
      @(posedge clk_sys);
      lag <= 8'h00;
      repeat (15) @(posedge clk_sys);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      cyc(2);
      chk({rd_data, oc_flag}, 20'h00000, "state after reset");
      t_last = 0;
      for (int i = 0; i < NUM_SIG; i++)
         avg[i] = FILTER_RST;
      round();
      $display("test reset in mid-run finished");
      give_verdict();
   end
endmodule : tb_port_power_monitor_trip
